// ---- pattern_group.sv ----
`timescale 1ns/1ps
`default_nettype none
// One 4-bit group: trigger selection and per-bit masked transfer
module pattern_group
  import pattern_pkg::*;
#(
  parameter int WIDTH = 4
)(
  input  wire logic [1:0]       sel,
  input  wire logic [2:0]       match,
  input  wire logic [WIDTH-1:0] next_data,
  input  wire logic [WIDTH-1:0] enable,
  input  wire logic [WIDTH-1:0] cur,
  output logic      [WIDTH-1:0] nxt,
  output logic                  fire
);
  // Refuse a group width that cannot hold a bit
  if (WIDTH < 1)
  begin : g_width_check
    $error("pattern_group: WIDTH must be positive");
  end

  // Channel 0 on 00, channel 1 on 01, channel 2 otherwise
  assign fire = (sel == SEL_CHAN0) ? match[0] :
                (sel == SEL_CHAN1) ? match[1] : match[2];
  // Enabled bits take next data on the trigger, others hold
  assign nxt  = fire ? ((next_data & enable) | (cur & ~enable)) : cur;
endmodule
`default_nettype wire

// ---- pattern_output.sv ----
// Functional notes
// - Port A direction: 8-bit write-only register
// - Port B direction: 8-bit write-only register
// - Port A data holds groups 0 and 1
// - Port B data holds groups 2 and 3
// - Enabled port A data bits ignore writes
// - Enabled port B data bits ignore writes
// - Trigger copies low buffer into port A
// - Trigger copies high buffer into port B
// - Buffers clear on reset and hardware standby
// - Shared low trigger: whole buffer at fffa5
// - Split low triggers: nibbles at fffa5/fffa7
// - Shared high trigger: whole buffer at fffa4
// - Split high triggers: nibbles at fffa4/fffa6
// - Disabled bits not copied; enables reset zero
// - Select 00/01/1x picks channel 0/1/2
`timescale 1ns/1ps
`default_nettype none
module pattern_output
  import pattern_pkg::*;
#(
  parameter int DATA_W = 8
)(
  input  wire logic        CLK,
  input  wire logic        RESET,
  input  wire logic        HW_STANDBY,
  input  wire logic [19:0] ADDR,
  input  wire logic [7:0]  WDATA,
  input  wire logic        WR,
  input  wire logic        RD,
  input  wire logic [2:0]  MATCH,
  output logic      [7:0]  RDATA,
  output logic      [7:0]  PORT_A_OUT,
  output logic      [7:0]  PORT_A_OE,
  output logic      [7:0]  PORT_B_OUT,
  output logic      [7:0]  PORT_B_OE
);
  // Refuse a data width that the byte-wide register map cannot serve
  if (DATA_W != 2 * GROUP_BITS)
  begin : g_width_check
    $error("pattern_output: DATA_W must be 8");
  end

  bus_req_t req;
  assign req = '{addr: ADDR, wdata: WDATA, wr: WR, rd: RD};

  logic [7:0] dir_a_q, dir_b_q, data_a_q, data_b_q;
  logic [7:0] next_low_q, next_high_q, en_low_q, en_high_q, trig_q, rdata_q;
  logic [7:0] next_low_d, next_high_d, data_a_d, data_b_d, rdata_d;
  logic [15:0] xfer;
  logic [3:0]  fire;
  logic        clr;
  logic        stby_s1_q, stby_s2_q, stby_s3_q, stby_q;

  // Synchronised hardware standby clears like reset
  assign clr = RESET | stby_q;

  // Address decode
  wire hit_hu  = req.addr == ADDR_NEXT_HIGH_UPPER;
  wire hit_lu  = req.addr == ADDR_NEXT_LOW_UPPER;
  wire hit_hl  = req.addr == ADDR_NEXT_HIGH_LOWER;
  wire hit_ll  = req.addr == ADDR_NEXT_LOW_LOWER;
  wire hit_enh = req.addr == ADDR_ENABLE_HIGH;
  wire hit_enl = req.addr == ADDR_ENABLE_LOW;
  wire hit_trg = req.addr == ADDR_TRIGGER_SELECT;
  wire hit_da  = req.addr == ADDR_PORT_A_DATA;
  wire hit_db  = req.addr == ADDR_PORT_B_DATA;
  wire hit_ra  = req.addr == ADDR_PORT_A_DIR;
  wire hit_rb  = req.addr == ADDR_PORT_B_DIR;

  // Write strobes per register
  wire wr_hu  = req.wr && hit_hu;
  wire wr_lu  = req.wr && hit_lu;
  wire wr_hl  = req.wr && hit_hl;
  wire wr_ll  = req.wr && hit_ll;
  wire wr_enh = req.wr && hit_enh;
  wire wr_enl = req.wr && hit_enl;
  wire wr_trg = req.wr && hit_trg;
  wire wr_da  = req.wr && hit_da;
  wire wr_db  = req.wr && hit_db;
  wire wr_ra  = req.wr && hit_ra;
  wire wr_rb  = req.wr && hit_rb;

  // Same trigger for paired groups selects the whole-byte layout
  wire same_low  = trig_q[3:2] == trig_q[1:0];
  wire same_high = trig_q[7:6] == trig_q[5:4];

  // Buffer byte lanes writable through each address
  wire [7:0] lu_mask = same_low  ? MASK_ALL  : MASK_UPPER;
  wire [7:0] ll_mask = same_low  ? MASK_NONE : MASK_LOWER;
  wire [7:0] hu_mask = same_high ? MASK_ALL  : MASK_UPPER;
  wire [7:0] hl_mask = same_high ? MASK_NONE : MASK_LOWER;

  wire [7:0] wr_low_mask  = wr_lu ? lu_mask : wr_ll ? ll_mask : MASK_NONE;
  wire [7:0] wr_high_mask = wr_hu ? hu_mask : wr_hl ? hl_mask : MASK_NONE;

  assign next_low_d  = (next_low_q & ~wr_low_mask) | (req.wdata & wr_low_mask);
  assign next_high_d = (next_high_q & ~wr_high_mask) | (req.wdata & wr_high_mask);

  // One transfer unit per group
  genvar g;
  generate
    for (g = 0; g < GROUPS; g++)
    begin : grp
      logic [7:0] nb, en, cur;
      assign nb  = (g < GROUPS / 2) ? next_low_q : next_high_q;
      assign en  = (g < GROUPS / 2) ? en_low_q : en_high_q;
      assign cur = (g < GROUPS / 2) ? data_a_q : data_b_q;
      pattern_group #(.WIDTH(GROUP_BITS)) u_group (
        .sel       (trig_q[2*g+1 -: 2]),
        .match     (MATCH),
        .next_data (nb[(g % 2) * GROUP_BITS +: GROUP_BITS]),
        .enable    (en[(g % 2) * GROUP_BITS +: GROUP_BITS]),
        .cur       (cur[(g % 2) * GROUP_BITS +: GROUP_BITS]),
        .nxt       (xfer[g * GROUP_BITS +: GROUP_BITS]),
        .fire      (fire[g])
      );
    end
  endgenerate

  // Port data: software writes only disabled bits, trigger updates enabled ones
  assign data_a_d = wr_da ? ((xfer[7:0] & en_low_q) | (req.wdata & ~en_low_q))
                          : xfer[7:0];
  assign data_b_d = wr_db ? ((xfer[15:8] & en_high_q) | (req.wdata & ~en_high_q))
                          : xfer[15:8];

  // Read mux; direction registers are write-only and read as ones
  assign rdata_d = !req.rd ? RESET_ZERO :
                   hit_lu  ? (next_low_q  | ~lu_mask) :
                   hit_ll  ? (next_low_q  | ~ll_mask) :
                   hit_hu  ? (next_high_q | ~hu_mask) :
                   hit_hl  ? (next_high_q | ~hl_mask) :
                   hit_enl ? en_low_q :
                   hit_enh ? en_high_q :
                   hit_trg ? trig_q :
                   hit_da  ? data_a_q :
                   hit_db  ? data_b_q :
                   READ_ONES;

  // Standby pin synchroniser: a level counts once stages two and three agree
  always_ff @(posedge CLK)
  begin
    if (RESET)
    begin
      stby_s1_q <= 1'b0;
      stby_s2_q <= 1'b0;
      stby_s3_q <= 1'b0;
      stby_q    <= 1'b0;
    end
    else
    begin
      stby_s1_q <= HW_STANDBY;
      stby_s2_q <= stby_s1_q;
      stby_s3_q <= stby_s2_q;
      if (stby_s2_q == stby_s3_q)
      begin
        stby_q <= stby_s3_q;
      end
    end
  end

  // Pattern buffers
  always_ff @(posedge CLK)
  begin
    if (clr)
    begin
      next_low_q  <= RESET_ZERO;
      next_high_q <= RESET_ZERO;
    end
    else
    begin
      next_low_q  <= next_low_d;
      next_high_q <= next_high_d;
    end
  end

  // Control registers
  always_ff @(posedge CLK)
  begin
    if (clr)
    begin
      dir_a_q   <= RESET_ZERO;
      dir_b_q   <= RESET_ZERO;
      en_low_q  <= RESET_ZERO;
      en_high_q <= RESET_ZERO;
      trig_q    <= RESET_TRIGGER;
    end
    else
    begin
      if (wr_ra) dir_a_q <= req.wdata;
      if (wr_rb) dir_b_q <= req.wdata;
      if (wr_enl) en_low_q <= req.wdata;
      if (wr_enh) en_high_q <= req.wdata;
      if (wr_trg) trig_q <= req.wdata;
    end
  end

  // Port data and read data
  always_ff @(posedge CLK)
  begin
    if (clr)
    begin
      data_a_q <= RESET_ZERO;
      data_b_q <= RESET_ZERO;
      rdata_q  <= RESET_ZERO;
    end
    else
    begin
      data_a_q <= data_a_d;
      data_b_q <= data_b_d;
      rdata_q  <= rdata_d;
    end
  end

  assign RDATA      = rdata_q;
  assign PORT_A_OUT = data_a_q;
  assign PORT_A_OE  = dir_a_q;
  assign PORT_B_OUT = data_b_q;
  assign PORT_B_OE  = dir_b_q;

  // Buffer clear on reset or hardware standby
  a_buf_reset: assert property (@(posedge CLK)
    $past(clr) |-> next_low_q == RESET_ZERO && next_high_q == RESET_ZERO)
    else $error("buffers not cleared");

  // Standby agreed by the synchroniser reaches the clear, then the buffers
  sequence s_standby_agreed;
    stby_s2_q && stby_s3_q;
  endsequence
  sequence s_standby_applied;
    stby_q ##1 (next_low_q == RESET_ZERO && next_high_q == RESET_ZERO);
  endsequence
  a_standby_clear: assert property (@(posedge CLK) disable iff (RESET)
    s_standby_agreed |=> s_standby_applied)
    else $error("standby did not clear the buffers");

  // Direction and select registers take each write whole
  a_dir_a_write: assert property (@(posedge CLK) disable iff (clr)
    wr_ra |=> dir_a_q == $past(req.wdata))
    else $error("port A direction not written");
  a_dir_b_write: assert property (@(posedge CLK) disable iff (clr)
    wr_rb |=> dir_b_q == $past(req.wdata))
    else $error("port B direction not written");
  a_trig_write: assert property (@(posedge CLK) disable iff (clr)
    wr_trg |=> trig_q == $past(req.wdata))
    else $error("trigger select not written");

  // Enabled port bits move only on their trigger
  a_port_a_lock: assert property (@(posedge CLK) disable iff (clr)
    !fire[0] && !fire[1] |=> ((data_a_q ^ $past(data_a_q)) & $past(en_low_q)) == RESET_ZERO)
    else $error("enabled port A bit changed by write");
  a_port_b_lock: assert property (@(posedge CLK) disable iff (clr)
    !fire[2] && !fire[3] |=> ((data_b_q ^ $past(data_b_q)) & $past(en_high_q)) == RESET_ZERO)
    else $error("enabled port B bit changed by write");

  // Disabled port bits take software writes
  a_port_a_write: assert property (@(posedge CLK) disable iff (clr)
    wr_da |=> (data_a_q & ~$past(en_low_q)) == ($past(req.wdata) & ~$past(en_low_q)))
    else $error("disabled port A bit not written");
  a_port_b_write: assert property (@(posedge CLK) disable iff (clr)
    wr_db |=> (data_b_q & ~$past(en_high_q)) == ($past(req.wdata) & ~$past(en_high_q)))
    else $error("disabled port B bit not written");

  // Disabled port bits hold through a trigger unless software writes them
  a_hold_low: assert property (@(posedge CLK) disable iff (clr)
    !wr_da |=> ((data_a_q ^ $past(data_a_q)) & ~$past(en_low_q)) == RESET_ZERO)
    else $error("disabled port A bit changed");
  a_hold_high: assert property (@(posedge CLK) disable iff (clr)
    !wr_db |=> ((data_b_q ^ $past(data_b_q)) & ~$past(en_high_q)) == RESET_ZERO)
    else $error("disabled port B bit changed");

  // Each group's enabled bits equal its buffer nibble after its trigger
  a_xfer_group0: assert property (@(posedge CLK) disable iff (clr)
    fire[0] |=> (data_a_q[3:0] & $past(en_low_q[3:0])) == ($past(next_low_q[3:0]) & $past(en_low_q[3:0])))
    else $error("group 0 transfer wrong");
  a_xfer_group1: assert property (@(posedge CLK) disable iff (clr)
    fire[1] |=> (data_a_q[7:4] & $past(en_low_q[7:4])) == ($past(next_low_q[7:4]) & $past(en_low_q[7:4])))
    else $error("group 1 transfer wrong");
  a_xfer_group2: assert property (@(posedge CLK) disable iff (clr)
    fire[2] |=> (data_b_q[3:0] & $past(en_high_q[3:0])) == ($past(next_high_q[3:0]) & $past(en_high_q[3:0])))
    else $error("group 2 transfer wrong");
  a_xfer_group3: assert property (@(posedge CLK) disable iff (clr)
    fire[3] |=> (data_b_q[7:4] & $past(en_high_q[7:4])) == ($past(next_high_q[7:4]) & $past(en_high_q[7:4])))
    else $error("group 3 transfer wrong");

  // Reserved addresses and nibbles read as ones
  a_reserved_ones: assert property (@(posedge CLK) disable iff (clr)
    req.rd && hit_ll && same_low |=> RDATA == READ_ONES)
    else $error("reserved low address not all ones");
  a_reserved_high: assert property (@(posedge CLK) disable iff (clr)
    req.rd && hit_hl && same_high |=> RDATA == READ_ONES)
    else $error("reserved high address not all ones");
  a_split_low: assert property (@(posedge CLK) disable iff (clr)
    req.rd && hit_lu && !same_low |=> RDATA[3:0] == NIBBLE_ONES)
    else $error("split low reserved nibble wrong");
  a_split_low_lower: assert property (@(posedge CLK) disable iff (clr)
    req.rd && hit_ll && !same_low |=> RDATA[7:4] == NIBBLE_ONES)
    else $error("split low lower reserved nibble wrong");
  a_split_high: assert property (@(posedge CLK) disable iff (clr)
    req.rd && hit_hu && !same_high |=> RDATA[3:0] == NIBBLE_ONES)
    else $error("split high reserved nibble wrong");
  a_split_high_lower: assert property (@(posedge CLK) disable iff (clr)
    req.rd && hit_hl && !same_high |=> RDATA[7:4] == NIBBLE_ONES)
    else $error("split high lower reserved nibble wrong");

  // Writes to reserved locations leave the buffers alone
  a_reserved_low_write: assert property (@(posedge CLK) disable iff (clr)
    wr_ll && same_low |=> next_low_q == $past(next_low_q))
    else $error("reserved low write changed the buffer");
  a_reserved_high_write: assert property (@(posedge CLK) disable iff (clr)
    wr_hl && same_high |=> next_high_q == $past(next_high_q))
    else $error("reserved high write changed the buffer");
endmodule
`default_nettype wire

// ---- pattern_pkg.sv ----
package pattern_pkg;

  // Register byte addresses (low 20 bits of the address)
  localparam logic [19:0] ADDR_NEXT_HIGH_UPPER = 20'hfffa4;
  localparam logic [19:0] ADDR_NEXT_LOW_UPPER  = 20'hfffa5;
  localparam logic [19:0] ADDR_NEXT_HIGH_LOWER = 20'hfffa6;
  localparam logic [19:0] ADDR_NEXT_LOW_LOWER  = 20'hfffa7;
  localparam logic [19:0] ADDR_ENABLE_HIGH     = 20'hfffa2;
  localparam logic [19:0] ADDR_ENABLE_LOW      = 20'hfffa3;
  localparam logic [19:0] ADDR_TRIGGER_SELECT  = 20'hfffa1;
  localparam logic [19:0] ADDR_PORT_A_DIR      = 20'hee009;
  localparam logic [19:0] ADDR_PORT_A_DATA     = 20'hfffd9;
  localparam logic [19:0] ADDR_PORT_B_DIR      = 20'hee00a;
  localparam logic [19:0] ADDR_PORT_B_DATA     = 20'hfffda;

  // Reset values and reserved read-back values
  localparam logic [7:0] RESET_ZERO    = 8'h00;
  localparam logic [7:0] RESET_TRIGGER = 8'hff;
  localparam logic [7:0] READ_ONES     = 8'hff;
  localparam logic [3:0] NIBBLE_ONES   = 4'hf;

  // Byte-lane masks for the buffer address layouts
  localparam logic [7:0] MASK_ALL   = 8'hff;
  localparam logic [7:0] MASK_NONE  = 8'h00;
  localparam logic [7:0] MASK_UPPER = 8'hf0;
  localparam logic [7:0] MASK_LOWER = 8'h0f;

  // Trigger select codes for one group
  localparam logic [1:0] SEL_CHAN0 = 2'h0;
  localparam logic [1:0] SEL_CHAN1 = 2'h1;

  localparam int GROUPS     = 4;
  localparam int GROUP_BITS = 4;

  // Register bus request
  typedef struct packed {
    logic [19:0] addr;
    logic [7:0]  wdata;
    logic        wr;
    logic        rd;
  } bus_req_t;

endpackage

// ---- test_timed_pattern_output_data.sv ----
`timescale 1ns/1ps
`default_nettype none
module test_timed_pattern_output_data;
  import pattern_pkg::*;
  logic       clk, reset, standby, wr, rd;
  logic [19:0] addr;
  logic [7:0]  wdata, rdata, a_out, a_oe, b_out, b_oe;
  logic [2:0]  match;
  int          n_errors, n_compared;

  pattern_output i_dut (.CLK(clk), .RESET(reset), .HW_STANDBY(standby), .ADDR(addr), .WDATA(wdata),
    .WR(wr), .RD(rd), .MATCH(match), .RDATA(rdata), .PORT_A_OUT(a_out), .PORT_A_OE(a_oe),
    .PORT_B_OUT(b_out), .PORT_B_OE(b_oe));
  timer_match_model i_timer (.clk(clk), .match(match));

  // Clock only; time-zero input values are set in the main sequence
  initial
  begin
    clk = 0;
    forever #20 clk = ~clk;
  end

  task automatic conclude();
    if (n_errors == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask

  // One-cycle write strobe
  task automatic wr_reg(input logic [19:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= 1; addr <= a; wdata <= d;
    @(posedge clk);
    wr <= 0;
    #1;
  endtask

  // Read data stands in the cycle after the strobe
  task automatic rd_reg(input logic [19:0] a, output logic [7:0] d);
    @(posedge clk);
    rd <= 1; addr <= a;
    @(posedge clk);
    rd <= 0;
    #1;
    d = rdata;
  endtask

  task automatic reset_values();
    logic [7:0] d;
    rd_reg(ADDR_NEXT_HIGH_UPPER, d); check(d, 8'h00);
    rd_reg(ADDR_NEXT_LOW_UPPER, d);  check(d, 8'h00);
    rd_reg(ADDR_TRIGGER_SELECT, d);  check(d, 8'hff);
    rd_reg(ADDR_PORT_A_DIR, d);      check(d, 8'hff);
    rd_reg(20'h12345, d);            check(d, 8'hff);
    check(a_out, 8'h00);
  endtask

  task automatic shared_trigger();
    logic [7:0] d;
    wr_reg(ADDR_PORT_A_DIR, 8'hff); check(a_oe, 8'hff);
    wr_reg(ADDR_PORT_B_DIR, 8'h3c); check(b_oe, 8'h3c);
    wr_reg(ADDR_NEXT_LOW_UPPER, 8'h5a);
    wr_reg(ADDR_NEXT_HIGH_UPPER, 8'hc3);
    wr_reg(ADDR_NEXT_LOW_LOWER, 8'h00);
    wr_reg(ADDR_NEXT_HIGH_LOWER, 8'h00);
    rd_reg(ADDR_NEXT_LOW_LOWER, d);  check(d, 8'hff);
    rd_reg(ADDR_NEXT_HIGH_LOWER, d); check(d, 8'hff);
    wr_reg(ADDR_ENABLE_LOW, 8'hf0);
    wr_reg(ADDR_ENABLE_HIGH, 8'hff);
    wr_reg(ADDR_PORT_A_DATA, 8'hff); check(a_out, 8'h0f);
    i_timer.fire(2);
    check(a_out, 8'h5f);
    check(b_out, 8'hc3);
    wr_reg(ADDR_PORT_B_DATA, 8'h00); check(b_out, 8'hc3);
  endtask

  // Codes 00, 01, 10, 11 on groups 0..3
  task automatic split_triggers();
    logic [7:0] d;
    wr_reg(ADDR_TRIGGER_SELECT, 8'he4);
    wr_reg(ADDR_NEXT_LOW_UPPER, 8'h3c);
    wr_reg(ADDR_NEXT_LOW_LOWER, 8'ha9);
    wr_reg(ADDR_NEXT_HIGH_UPPER, 8'h5a);
    wr_reg(ADDR_NEXT_HIGH_LOWER, 8'h0c);
    rd_reg(ADDR_NEXT_LOW_UPPER, d);  check(d, 8'h3f);
    rd_reg(ADDR_NEXT_LOW_LOWER, d);  check(d, 8'hf9);
    rd_reg(ADDR_NEXT_HIGH_UPPER, d); check(d, 8'h5f);
    rd_reg(ADDR_NEXT_HIGH_LOWER, d); check(d, 8'hfc);
    wr_reg(ADDR_ENABLE_LOW, 8'hff);
    i_timer.fire(0);
    check(a_out, 8'h59);
    check(b_out, 8'hc3);
    i_timer.fire(1);
    check(a_out, 8'h39);
    i_timer.fire(2);
    check(b_out, 8'h5c);
    check(a_out, 8'h39);
  endtask

  // Standby stands long enough for the pin synchroniser to agree, both ways
  task automatic standby_clear();
    logic [7:0] d;
    @(posedge clk);
    standby <= 1;
    repeat (6) @(posedge clk);
    standby <= 0;
    repeat (6) @(posedge clk);
    rd_reg(ADDR_NEXT_HIGH_UPPER, d); check(d, 8'h00);
    rd_reg(ADDR_NEXT_LOW_UPPER, d);  check(d, 8'h00);
    rd_reg(ADDR_TRIGGER_SELECT, d);  check(d, 8'hff);
  endtask

  // Main sequence
  initial
  begin
    reset = 1; standby = 0; wr = 0; rd = 0; addr = 20'h00000; wdata = 8'h00;
    n_errors = 0; n_compared = 0;
    repeat (4) @(posedge clk);
    reset <= 0;
    reset_values();
    shared_trigger();
    split_triggers();
    standby_clear();
    conclude();
  end

  // Watchdog at 5000 cycles, well beyond the under 100 cycles needed
  initial
  begin
    #200000;
    n_errors++;
    conclude();
  end
endmodule
`default_nettype wire

// ---- timer_match_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// Compare-match source of the three timer channels
module timer_match_model (
  input  wire logic       clk,
  output logic      [2:0] match
);
  initial match = 3'h0;
  // One-cycle pulse on one channel, launched after a rising edge
  task automatic fire(input int ch);
    @(posedge clk);
    match[ch] <= 1'b1;
    @(posedge clk);
    match <= 3'h0;
    #1;
  endtask
endmodule
`default_nettype wire
